// ### hw/lkr_pkg.sv
// Package for the link error and PHY test register slice.
// Assumes a 32-bit AXI4-Lite master and a PHY macro on the same clock.
package lkr_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_PHY_SIGNAL_STATUS = 8'hb0;
  localparam logic [7:0] OFS_PHY_TEST_CTRL_LO  = 8'hb4;
  localparam logic [7:0] OFS_PHY_TEST_CTRL_HI  = 8'hb8;
  localparam logic [7:0] OFS_ERR_STATUS_A      = 8'hbc;
  localparam logic [7:0] OFS_ERR_STATUS_B      = 8'hc0;
  localparam logic [7:0] OFS_ERR_MASK_A        = 8'hc4;
  localparam logic [7:0] OFS_ERR_MASK_B        = 8'hc8;
  localparam logic [7:0] OFS_ERR_CLEAR_A       = 8'hcc;
  localparam logic [7:0] OFS_ERR_CLEAR_B       = 8'hd0;

  // ----------------------------------------
  // Field positions and widths
  // ----------------------------------------
  localparam int          TST_CLK_BIT   = 1;
  localparam int          TST_CLR_BIT   = 0;
  localparam int          TST_EN_BIT    = 16;
  localparam int          TST_DOUT_LSB  = 8;
  localparam int          TST_DIN_LSB   = 0;
  localparam int          ERR_A_W       = 21;
  localparam int          ERR_B_W       = 13;
  localparam int          PHY_STAT_W    = 13;
  localparam logic [1:0]  TST_LO_RESET  = 2'h1;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ----------------------------------------
  // Carried groups
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] lane_sleep_n;
    logic [2:0] lane_idle_state;
    logic       lane_zero_sleep_n;
    logic       lane_zero_idle_state;
    logic       clk_sleep_n;
    logic       clk_idle_state;
    logic       direction;
    logic       pll_lock;
  } lkr_phy_stat_t;

  typedef struct packed {
    logic       test_clk;
    logic       test_clr;
    logic       test_en;
    logic [7:0] test_din;
  } lkr_phy_test_t;

  // Event pulses, one cycle each; ack_err in report bit order
  typedef struct packed {
    logic [4:0]  lane_zero_err;
    logic [15:0] ack_err;
  } lkr_err_a_t;

  typedef struct packed {
    logic gen_rcv_full;
    logic dcs_rd_empty;
    logic gen_send_empty;
    logic gen_pld_wr_full;
    logic gen_cmd_wr_full;
    logic pix_pld_full;
    logic no_eot;
    logic pkt_size;
    logic crc;
    logic ecc_multi;
    logic ecc_single;
    logic slow_receive_timeout;
    logic fast_transmit_timeout;
  } lkr_err_b_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } lkr_wr_state_t;

endpackage

// ### hw/lkr_regs.sv
// Register slice: PHY status mirror, PHY test port, error status and masks.
// Assumes all PHY and datapath signals are synchronous to clk.
module lkr_regs
  import lkr_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // AXI4-Lite write address
  input  wire logic [7:0]          s_awaddr,
  input  wire logic                s_awvalid,
  output logic                     s_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]         s_wdata,
  input  wire logic [3:0]          s_wstrb,
  input  wire logic                s_wvalid,
  output logic                     s_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_bresp,
  output logic                     s_bvalid,
  input  wire logic                s_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]          s_araddr,
  input  wire logic                s_arvalid,
  output logic                     s_arready,
  // AXI4-Lite read data
  output logic [31:0]              s_rdata,
  output logic [1:0]               s_rresp,
  output logic                     s_rvalid,
  input  wire logic                s_rready,
  // PHY status and test port
  input  wire lkr_phy_stat_t       phy_stat,
  input  wire logic [7:0]          phy_test_dout,
  output lkr_phy_test_t            phy_test,
  // Error events
  input  wire lkr_err_a_t          err_a_evt,
  input  wire lkr_err_b_t          err_b_evt,
  // FIFO write attempts from the generic interface
  input  wire logic                gen_pld_wr_req,
  input  wire logic                gen_pld_full,
  input  wire logic                gen_cmd_wr_req,
  input  wire logic                gen_cmd_full,
  output logic                     gen_pld_wr_en,
  output logic                     gen_cmd_wr_en,
  // Interrupt
  output logic                     irq
);

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  lkr_wr_state_t    wr_state_q;
  logic             aw_got_q;
  logic             w_got_q;
  logic [7:0]       awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic [1:0]       bresp_q;
  logic             wr_fire;
  logic             wr_hit;

  assign s_awready = (wr_state_q == WR_IDLE) && !aw_got_q;
  assign s_wready  = (wr_state_q == WR_IDLE) && !w_got_q;
  assign s_bvalid  = (wr_state_q == WR_RESP);
  assign s_bresp   = bresp_q;
  // Both halves held, committed in the same edge the response starts
  assign wr_fire   = (wr_state_q == WR_IDLE) && aw_got_q && w_got_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_got_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_awvalid && s_awready) begin
      aw_got_q <= 1'b1;
      awaddr_q <= s_awaddr;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      w_got_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_wvalid && s_wready) begin
      w_got_q <= 1'b1;
      wdata_q <= s_wdata;
      wstrb_q <= s_wstrb;
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end
  end

  always_comb begin
    unique case ({awaddr_q[7:2], 2'b00})
      OFS_PHY_SIGNAL_STATUS, OFS_PHY_TEST_CTRL_LO, OFS_PHY_TEST_CTRL_HI,
      OFS_ERR_STATUS_A, OFS_ERR_STATUS_B, OFS_ERR_MASK_A, OFS_ERR_MASK_B,
      OFS_ERR_CLEAR_A, OFS_ERR_CLEAR_B: wr_hit = 1'b1;
      default:                          wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_state_q <= WR_IDLE;
      bresp_q    <= RESP_OKAY;
    end else begin
      unique case (wr_state_q)
        WR_IDLE: begin
          if (wr_fire) begin
            wr_state_q <= WR_RESP;
            bresp_q    <= wr_hit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_bready) begin
            wr_state_q <= WR_IDLE;
          end
        end
        default: wr_state_q <= WR_IDLE;
      endcase
    end
  end

  // Strobed byte merge for the test control and mask registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic wr_to(input logic [7:0] a, input logic [7:0] ofs);
    return {a[7:2], 2'b00} == ofs;
  endfunction

  // ----------------------------------------
  // PHY test control
  // ----------------------------------------
  logic [1:0]  tst_lo_q;
  logic [16:0] tst_hi_q;
  logic [31:0] tst_lo_m;
  logic [31:0] tst_hi_m;

  assign tst_lo_m = merge({30'h0, tst_lo_q}, wdata_q, wstrb_q);
  assign tst_hi_m = merge({15'h0, tst_hi_q}, wdata_q, wstrb_q);

  lkr_sw_reg #(.W(2), .RST(TST_LO_RESET)) u_tst_lo (
    .clk     (clk),
    .nrst    (nrst),
    .load    (wr_fire && wr_to(awaddr_q, OFS_PHY_TEST_CTRL_LO)),
    .val     (tst_lo_m[1:0]),
    .value_q (tst_lo_q)
  );

  lkr_sw_reg #(.W(17), .RST(17'h0_0000)) u_tst_hi (
    .clk     (clk),
    .nrst    (nrst),
    .load    (wr_fire && wr_to(awaddr_q, OFS_PHY_TEST_CTRL_HI)),
    .val     (tst_hi_m[16:0]),
    .value_q (tst_hi_q)
  );

  // Straight from flops: software paces the PHY test clock edges itself
  assign phy_test.test_clk = tst_lo_q[TST_CLK_BIT];
  assign phy_test.test_clr = tst_lo_q[TST_CLR_BIT];
  assign phy_test.test_en  = tst_hi_q[TST_EN_BIT];
  assign phy_test.test_din = tst_hi_q[TST_DIN_LSB +: 8];

  // ----------------------------------------
  // Generic FIFO write gating
  // ----------------------------------------
  assign gen_pld_wr_en = gen_pld_wr_req && !gen_pld_full;
  assign gen_cmd_wr_en = gen_cmd_wr_req && !gen_cmd_full;

  // ----------------------------------------
  // Error status, masks and interrupt
  // ----------------------------------------
  logic [ERR_A_W-1:0] err_a_q;
  logic [ERR_B_W-1:0] err_b_q;
  logic [ERR_A_W-1:0] msk_a_q;
  logic [ERR_B_W-1:0] msk_b_q;
  logic [ERR_A_W-1:0] set_a;
  logic [ERR_B_W-1:0] set_b;
  logic [ERR_A_W-1:0] clr_a;
  logic [ERR_B_W-1:0] clr_b;
  logic [31:0]        msk_a_m;
  logic [31:0]        msk_b_m;

  assign set_a = {err_a_evt.lane_zero_err, err_a_evt.ack_err};
  // Overflow bits come from dropped attempts, not from a separate event
  assign set_b = {err_b_evt.gen_rcv_full, err_b_evt.dcs_rd_empty,
                  err_b_evt.gen_send_empty,
                  gen_pld_wr_req && gen_pld_full, gen_cmd_wr_req && gen_cmd_full,
                  err_b_evt.pix_pld_full, err_b_evt.no_eot,
                  err_b_evt.pkt_size, err_b_evt.crc,
                  err_b_evt.ecc_multi, err_b_evt.ecc_single,
                  err_b_evt.slow_receive_timeout, err_b_evt.fast_transmit_timeout};

  assign clr_a = (wr_fire && wr_to(awaddr_q, OFS_ERR_CLEAR_A)) ? wdata_q[ERR_A_W-1:0] : '0;
  assign clr_b = (wr_fire && wr_to(awaddr_q, OFS_ERR_CLEAR_B)) ? wdata_q[ERR_B_W-1:0] : '0;

  lkr_sticky #(.W(ERR_A_W)) u_err_a (
    .clk    (clk),
    .nrst   (nrst),
    .evt    (set_a),
    .clr    (clr_a),
    .flag_q (err_a_q)
  );

  lkr_sticky #(.W(ERR_B_W)) u_err_b (
    .clk    (clk),
    .nrst   (nrst),
    .evt    (set_b),
    .clr    (clr_b),
    .flag_q (err_b_q)
  );

  assign msk_a_m = merge({11'h0, msk_a_q}, wdata_q, wstrb_q);
  assign msk_b_m = merge({19'h0, msk_b_q}, wdata_q, wstrb_q);

  lkr_sw_reg #(.W(ERR_A_W)) u_msk_a (
    .clk     (clk),
    .nrst    (nrst),
    .load    (wr_fire && wr_to(awaddr_q, OFS_ERR_MASK_A)),
    .val     (msk_a_m[ERR_A_W-1:0]),
    .value_q (msk_a_q)
  );

  lkr_sw_reg #(.W(ERR_B_W)) u_msk_b (
    .clk     (clk),
    .nrst    (nrst),
    .load    (wr_fire && wr_to(awaddr_q, OFS_ERR_MASK_B)),
    .val     (msk_b_m[ERR_B_W-1:0]),
    .value_q (msk_b_q)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(err_a_q & msk_a_q) || |(err_b_q & msk_b_q);
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        rvalid_q;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic [PHY_STAT_W-1:0] phy_word;

  // Lane pairs 3..1 with the sleep bit above the idle bit, then lane 0 down
  assign phy_word = {phy_stat.lane_sleep_n[2], phy_stat.lane_idle_state[2],
                     phy_stat.lane_sleep_n[1], phy_stat.lane_idle_state[1],
                     phy_stat.lane_sleep_n[0], phy_stat.lane_idle_state[0],
                     1'b0,
                     phy_stat.lane_zero_sleep_n, phy_stat.lane_zero_idle_state,
                     phy_stat.clk_sleep_n, phy_stat.clk_idle_state,
                     phy_stat.direction, phy_stat.pll_lock};

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case ({s_araddr[7:2], 2'b00})
      OFS_PHY_SIGNAL_STATUS: rd_mux = {19'h0, phy_word};
      OFS_PHY_TEST_CTRL_LO:  rd_mux = {30'h0, tst_lo_q};
      OFS_PHY_TEST_CTRL_HI:  rd_mux = {15'h0, tst_hi_q[TST_EN_BIT], phy_test_dout,
                                      tst_hi_q[7:0]};
      OFS_ERR_STATUS_A:      rd_mux = {11'h0, err_a_q};
      OFS_ERR_STATUS_B:      rd_mux = {19'h0, err_b_q};
      OFS_ERR_MASK_A:        rd_mux = {11'h0, msk_a_q};
      OFS_ERR_MASK_B:        rd_mux = {19'h0, msk_b_q};
      OFS_ERR_CLEAR_A, OFS_ERR_CLEAR_B: rd_mux = 32'h0000_0000;
      default:               rd_hit = 1'b0;
    endcase
  end

  assign s_arready = !rvalid_q;
  assign s_rvalid  = rvalid_q;
  assign s_rdata   = rdata_q;
  assign s_rresp   = rresp_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// ----------------------------------------
// Software register with a load strobe
// ----------------------------------------
module lkr_sw_reg
  import lkr_pkg::*;
#(
  parameter int           W   = 8,
  parameter logic [W-1:0] RST = '0
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Load strobe and new value
  input  wire logic         load,
  input  wire logic [W-1:0] val,
  // Held value
  output logic [W-1:0]      value_q
);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      value_q <= RST;
    end else if (load) begin
      value_q <= val;
    end
  end

endmodule

// ----------------------------------------
// Sticky flags with write-one clear
// ----------------------------------------
module lkr_sticky
  import lkr_pkg::*;
#(
  parameter int W = 8
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Events and software clear
  input  wire logic [W-1:0] evt,
  input  wire logic [W-1:0] clr,
  // Flags
  output logic [W-1:0]      flag_q
);

  // Set wins over a clear in the same cycle, so no event is lost
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~clr) | evt;
    end
  end

endmodule

// ### testbench/lkr_regs_assertions.sv
// Port-level checker for the link error and PHY test register slice.
// Assumes one clock domain, nrst asynchronous and active low.
module lkr_regs_assertions
  import lkr_pkg::*;
(
  // Clock and reset
  input wire logic          clk,
  input wire logic          nrst,
  // Bus answers
  input wire logic [1:0]    s_bresp,
  input wire logic          s_bvalid,
  input wire logic          s_bready,
  input wire logic          s_arvalid,
  input wire logic          s_arready,
  input wire logic [31:0]   s_rdata,
  input wire logic          s_rvalid,
  input wire logic          s_rready,
  // PHY test port and FIFO gates
  input wire lkr_phy_test_t phy_test,
  input wire logic          gen_pld_wr_req,
  input wire logic          gen_pld_full,
  input wire logic          gen_pld_wr_en,
  input wire logic          gen_cmd_wr_req,
  input wire logic          gen_cmd_full,
  input wire logic          gen_cmd_wr_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_pld_gate: assert property (gen_pld_wr_en == (gen_pld_wr_req && !gen_pld_full))
    else $error("payload write gate wrong");
  a_cmd_gate: assert property (gen_cmd_wr_en == (gen_cmd_wr_req && !gen_cmd_full))
    else $error("command write gate wrong");
  // Test pins only move as a write lands, never on their own
  a_test_on_write: assert property ($changed(phy_test) |-> s_bvalid)
    else $error("test port moved without a write");
  a_bresp_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped early");
  a_ar_refuse: assert property (s_arready == !s_rvalid)
    else $error("read address ready wrong");
  a_r_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  a_r_single: assert property (s_rvalid && s_rready |=> !s_rvalid)
    else $error("read answer repeated");
endmodule

bind lkr_regs lkr_regs_assertions u_chk (
  .clk(clk), .nrst(nrst), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid),
  .s_rready(s_rready), .phy_test(phy_test), .gen_pld_wr_req(gen_pld_wr_req),
  .gen_pld_full(gen_pld_full), .gen_pld_wr_en(gen_pld_wr_en), .gen_cmd_wr_req(gen_cmd_wr_req),
  .gen_cmd_full(gen_cmd_full), .gen_cmd_wr_en(gen_cmd_wr_en)
);

// ### testbench/lkr_phy_model.sv
// Behavioural PHY: status levels and a test register port.
// Assumes test pins are levels from the register slice.
module lkr_phy_model
  import lkr_pkg::*;
(
  // Test port
  input wire lkr_phy_test_t test,
  output logic [7:0]        dout,
  // Status
  input wire lkr_phy_stat_t stat_in,
  output lkr_phy_stat_t     stat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] addr_q;
  logic [7:0] mem_q [256];
  assign stat = stat_in;
  // Address on the falling edge while enabled; clear wins
  always @(negedge test.test_clk or posedge test.test_clr) begin
    if (test.test_clr) addr_q <= 8'h00;
    else if (test.test_en) addr_q <= test.test_din;
  end
  always @(posedge test.test_clk) begin
    if (!test.test_en && !test.test_clr) mem_q[addr_q] <= test.test_din;
  end
  // Unwritten places read unknown, as a real macro may
  assign dout = mem_q[addr_q];
endmodule

// ### testbench/lkr_regs_tb_top.sv
// Self-checking bench for the register slice over AXI4-Lite.
// Assumes the PHY model and checker files are compiled first.
module lkr_regs_tb_top;
  import lkr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk, nrst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic          s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
  logic [7:0]    s_awaddr, s_araddr, phy_test_dout;
  logic [31:0]   s_wdata, s_rdata;
  logic [3:0]    s_wstrb;
  logic [1:0]    s_bresp, s_rresp, en;
  lkr_phy_stat_t phy_stat, stat_in;
  lkr_phy_test_t phy_test;
  lkr_err_a_t    err_a_evt;
  lkr_err_b_t    err_b_evt;
  logic          gen_pld_wr_req, gen_pld_full, gen_cmd_wr_req, gen_cmd_full;
  logic          gen_pld_wr_en, gen_cmd_wr_en;
  int            fail_count, comparisons;

  lkr_regs dut (.clk(clk), .nrst(nrst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .phy_stat(phy_stat),
    .phy_test_dout(phy_test_dout), .phy_test(phy_test), .err_a_evt(err_a_evt),
    .err_b_evt(err_b_evt), .gen_pld_wr_req(gen_pld_wr_req), .gen_pld_full(gen_pld_full),
    .gen_cmd_wr_req(gen_cmd_wr_req), .gen_cmd_full(gen_cmd_full),
    .gen_pld_wr_en(gen_pld_wr_en), .gen_cmd_wr_en(gen_cmd_wr_en), .irq(irq));
  lkr_phy_model u_phy (.test(phy_test), .dout(phy_test_dout), .stat_in(stat_in),
    .stat(phy_stat));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_limit(input int n);
    if (n >= 64) begin
      fail_count++;
      stop_test();
    end
  endtask
  // Ready is sampled at the falling edge, so the decision uses settled values
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    logic ka, kw, bv;
    logic [1:0] r;
    @(posedge clk);
    {s_awaddr, s_wdata} <= {a, d};
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    n = 0;
    bv = 0;
    while (!bv && n < 64) begin
      @(negedge clk);
      {ka, kw, bv, r} = {s_awvalid & s_awready, s_wvalid & s_wready, s_bvalid, s_bresp};
      @(posedge clk);
      if (ka) s_awvalid <= 1'b0;
      if (kw) s_wvalid <= 1'b0;
      n++;
    end
    s_bready <= 1'b0;
    wait_limit(n);
    check(r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
    int n;
    logic k, rv;
    logic [31:0] dat;
    logic [1:0] r;
    @(posedge clk);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'h3;
    n = 0;
    rv = 0;
    while (!rv && n < 64) begin
      @(negedge clk);
      {k, rv, dat, r} = {s_arvalid & s_arready, s_rvalid, s_rdata, s_rresp};
      @(posedge clk);
      if (k) s_arvalid <= 1'b0;
      n++;
    end
    s_rready <= 1'b0;
    wait_limit(n);
    check(dat, x);
    check(r, e);
  endtask
  task automatic pulse(input logic [20:0] a, input logic [12:0] b, input logic [1:0] g);
    @(posedge clk);
    {err_a_evt, err_b_evt, gen_pld_wr_req, gen_cmd_wr_req} <= {a, b, g};
    @(negedge clk) en = {gen_pld_wr_en, gen_cmd_wr_en};
    @(posedge clk);
    {err_a_evt, err_b_evt, gen_pld_wr_req, gen_cmd_wr_req} <= '0;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {nrst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, err_a_evt, err_b_evt} = '0;
    {gen_pld_wr_req, gen_cmd_wr_req, gen_pld_full, gen_cmd_full} = 4'h3;
    s_wstrb = 4'hf;
    stat_in = '0;
    fail_count = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    check(phy_test.test_clr, 1);
    rd(8'hb4, 32'h1, RESP_OKAY);
    for (int i = 0; i < 4; i++) rd(8'hbc + 8'(4 * i), 0, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      stat_in <= lkr_phy_stat_t'(i ? 12'h552 : 12'haad);
      rd(8'hb0, i ? 32'h0c92 : 32'h132d, RESP_OKAY);
    end
    wr(8'hb4, 0, RESP_OKAY);
    check(phy_test.test_clr, 0);
    wr(8'hb8, 32'h1005a, RESP_OKAY);
    check({phy_test.test_en, phy_test.test_din}, 9'h15a);
    wr(8'hb4, 2, RESP_OKAY);
    check(phy_test.test_clk, 1);
    wr(8'hb4, 0, RESP_OKAY);
    wr(8'hb8, 32'hc3, RESP_OKAY);
    wr(8'hb4, 2, RESP_OKAY);
    rd(8'hb8, 32'hc3c3, RESP_OKAY);
    for (int i = 0; i < 21; i++) begin
      pulse(21'h1 << i, 0, 0);
      rd(8'hbc, 32'h1 << i, RESP_OKAY);
      check(irq, 0);
      wr(8'hcc, 32'h1 << i, RESP_OKAY);
    end
    for (int i = 0; i < 13; i++) begin
      pulse(0, (i == 8 || i == 9) ? 13'h0 : 13'h1 << i, {i == 9, i == 8});
      check(en, 0);
      rd(8'hc0, 1 << i, 2'h0);
      wr(8'hd0, 32'h1 << i, RESP_OKAY);
    end
    {gen_pld_full, gen_cmd_full} <= 2'h0;
    pulse(0, 0, 2'h3);
    check(en, 2'h3);
    rd(8'hc0, 0, RESP_OKAY);
    wr(8'hc4, 32'hffffffff, RESP_OKAY);
    rd(8'hc4, 32'h1fffff, RESP_OKAY);
    wr(8'hc8, 32'hffffffff, RESP_OKAY);
    rd(8'hc8, 32'h1fff, RESP_OKAY);
    pulse(0, 13'h1, 0);
    repeat (2) @(negedge clk);
    check(irq, 1);
    wr(8'hc8, 0, RESP_OKAY);
    @(negedge clk) check(irq, 0);
    pulse(21'h100000, 0, 0);
    repeat (2) @(negedge clk);
    check(irq, 1);
    wr(8'hcc, 32'h100000, RESP_OKAY);
    @(negedge clk) check(irq, 0);
    // Unmapped place refused, status place ignores writes
    wr(8'h10, 32'hffffffff, RESP_SLVERR);
    rd(8'h10, 0, RESP_SLVERR);
    wr(8'hbc, 32'hffffffff, RESP_OKAY);
    rd(8'hbc, 0, RESP_OKAY);
    stop_test();
  end
endmodule
